// ==== rtl/cadp_decode.sv ====
module cadp_decode
  import cadp_pkg::*;
#(
  parameter logic [23:0] PERIPH_BASE = CADP_PERIPH_BASE,
  parameter logic [23:0] FLAG_ADDR   = CADP_FLAG_ADDR,
  parameter logic [23:0] FAULT_ADDR  = CADP_FAULT_ADDR,
  parameter logic [23:0] MAP_LO      = CADP_MAP_LO,
  parameter logic [23:0] MAP_HI      = CADP_MAP_HI,
  parameter cadp_rom_size_t ROM_SIZE = CADP_ROM_2K
) (
  input  wire logic        REF_CLK,        // 20 MHz clock.
  input  wire logic        RESET_N,        // Synchronous reset, active low.
  input  wire logic [23:0] ADDR,           // Processor byte address.
  input  wire logic        AS,             // Address strobe, active high.
  input  wire logic        RW,             // High for read.
  input  wire logic        BHEN,           // Byte-high enable.
  input  wire logic [2:0]  FC,             // Function code lines.
  input  wire logic        MRDC,           // Memory read command.
  input  wire logic        MWTC,           // Memory write command.
  input  wire logic        BUS_HELD_LOCAL, // Local busy term.
  input  wire logic [7:0]  DATA_IN,        // Low data byte from the processor.
  input  wire logic [15:0] MAP_ENTRY,      // Current translation entry.
  output logic [15:0]      PERIPH_SEL,     // One-hot peripheral select.
  output logic             ARRAY_SEL,      // Translation array select.
  output logic             ROM_SEL,        // On-board ROM select.
  output logic [3:0]       ROM_PAIR_SEL_N, // Per-pair ROM selects, active low.
  output logic             XFER_ACK,       // Transfer acknowledge.
  output logic             LOW_WORD_HALF_STROBE,
  output logic             UPPER_WORD_HALF_STROBE,
  output logic             LOW_LANE_ENABLE,
  output logic             HIGH_LANE_ENABLE,
  output logic             SWAP_LANE_ENABLE,
  output logic             ONBOARD_IO_ACK,
  output logic             FAULT_REG_READ_PICK,
  output logic             XLATE_FLAG_WRITE_STROBE,
  output logic             SUPERVISOR_XLATE_ENABLE,
  output logic             VALID_ADDRESS_STROBE,
  output logic             OUTSIDE_USER_FAULT,
  output logic             WRITE_PROTECT_FAULT,
  output logic             SEGMENT_INVALID_FAULT,
  output logic             SEGMENT_ABSENT_FAULT,
  output logic             FAULT_IRQ_CLEAR  // Pulse: clears level-seven request.
);

  // ==========================================================
  // Parameter checks
  // ==========================================================
  // The on-board I/O block is found from address bits 23..11 of the array base,
  // so a base off a 2K boundary would silently widen or shift that block.
  if (MAP_LO[10:0] != 11'h000 || MAP_HI < MAP_LO) begin : g_bad_map
    $error("Translation array base must sit on a 2K boundary below its top.");
  end

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  // Pins come from the processor bus, so every one is double registered.
  localparam int IW = 24 + 1 + 1 + 1 + 3 + 1 + 1 + 1 + 8 + 16;
  logic [IW-1:0] meta_r;
  logic [IW-1:0] sync_r;
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {ADDR, AS, RW, BHEN, FC, MRDC, MWTC, BUS_HELD_LOCAL, DATA_IN, MAP_ENTRY};
      sync_r <= meta_r;
    end
  end

  logic [23:0] a;
  logic        as_s, rw_s, bhen_s, mrdc_s, mwtc_s, busy_s;
  logic [2:0]  fc_s;
  logic [7:0]  din_s;
  logic [15:0] entry_s;
  assign {a, as_s, rw_s, bhen_s, fc_s, mrdc_s, mwtc_s, busy_s, din_s, entry_s} = sync_r;

  // ==========================================================
  // Region decode
  // ==========================================================
  function automatic logic in_span(input logic [23:0] x, input logic [23:0] lo,
                                   input logic [23:0] hi);
    in_span = (x >= lo) && (x <= hi);
  endfunction : in_span

  function automatic logic [23:0] rom_end(input cadp_rom_size_t sz);
    case (sz)
      CADP_ROM_4K: rom_end = CADP_ROM_END_4K;
      CADP_ROM_8K: rom_end = CADP_ROM_END_8K;
      default:     rom_end = CADP_ROM_END_2K;
    endcase
  endfunction : rom_end

  // Off-board memory and I/O spaces fall through every decode below.
  logic periph_hit, array_hit, rom_hit, map_hit, flag_hit, fault_hit, io_hit;
  assign periph_hit = (a[23:8] == PERIPH_BASE[23:8]);
  assign array_hit  = in_span(a, CADP_ARRAY_LO, CADP_ARRAY_HI);
  assign rom_hit    = (a[23:16] == 8'h00) && (a <= rom_end(ROM_SIZE));
  assign map_hit    = in_span(a, MAP_LO, MAP_HI);
  assign flag_hit   = (a == FLAG_ADDR);
  assign fault_hit  = (a == FAULT_ADDR);
  // On-board I/O space is the block holding flag, fault register and map.
  assign io_hit     = (a[23:11] == MAP_LO[23:11]) || flag_hit || fault_hit;

  // ==========================================================
  // ROM pair lookup
  // ==========================================================
  // Entry index is address bits 15..11, so each entry covers 2K bytes.
  function automatic logic [3:0] rom_lut(input cadp_rom_size_t sz, input logic [4:0] i);
    logic [3:0] v;
    v = CADP_NO_PAIR;
    case (sz)
      CADP_ROM_4K: begin
        case (i)
          5'h00, 5'h01: v = 4'hE;
          5'h02, 5'h03: v = 4'hD;
          5'h04:        v = 4'hB;
          5'h05, 5'h06: v = 4'h7;
          default:      v = CADP_NO_PAIR;
        endcase
      end
      CADP_ROM_8K: begin
        if (i < 5'h04) v = 4'hE;
        else if (i < 5'h07) v = 4'hD;
        else if (i == 5'h07 || i > 5'h0B) v = (i < 5'h10) ? 4'h7 : CADP_NO_PAIR;
        else v = 4'hB;
      end
      default: begin
        case (i)
          5'h00: v = 4'hE;
          5'h01: v = 4'hD;
          5'h02: v = 4'hB;
          default: v = CADP_NO_PAIR;
        endcase
      end
    endcase
    rom_lut = v;
  endfunction : rom_lut

  // ==========================================================
  // Byte lanes
  // ==========================================================
  cadp_lane_if lane ();
  assign lane.sel  = rom_hit || io_hit || periph_hit || array_hit;
  assign lane.a0   = a[0];
  assign lane.bhen = bhen_s;
  cadp_lane_gen u_lane (.lane(lane));

  // ==========================================================
  // Translation flag and protection
  // ==========================================================
  logic user_state, intack, mapped, io_cmd, flag_wr, fault_rd, user_space;
  assign user_state = !fc_s[2];
  assign intack     = (fc_s == 3'h7);
  assign user_space = (a <= CADP_USER_TOP);
  assign io_cmd     = io_hit && busy_s && (mrdc_s || mwtc_s);
  assign fault_rd   = io_hit && mrdc_s && a[10] && !a[9] && a[8] && !a[0];
  assign flag_wr    = io_hit && mwtc_s && busy_s && a[10] && !a[9] && !a[8] && !a[0];

  logic flag_r;
  logic flag_nxt;
  always_comb begin
    flag_nxt = flag_r;
    if (flag_wr) flag_nxt = (din_s == CADP_FLAG_ON);
    if (intack) flag_nxt = 1'b0;
  end
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) flag_r <= 1'b0;
    else flag_r <= flag_nxt;
  end

  // User cycles in user space are translated; supervisor ones only when the flag is set.
  assign mapped = as_s && user_space && (user_state || flag_r);

  logic fault_rd_d_r;
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) fault_rd_d_r <= 1'b0;
    else fault_rd_d_r <= fault_rd;
  end

  // ==========================================================
  // Registered outputs
  // ==========================================================
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      PERIPH_SEL     <= '0;
      ARRAY_SEL      <= 1'b0;
      ROM_SEL        <= 1'b0;
      ROM_PAIR_SEL_N <= CADP_NO_PAIR;
      XFER_ACK       <= 1'b0;
    end else begin
      PERIPH_SEL     <= periph_hit ? (16'h0001 << a[7:4]) : 16'h0000;
      ARRAY_SEL      <= array_hit || map_hit;
      ROM_SEL        <= rom_hit;
      ROM_PAIR_SEL_N <= rom_hit ? rom_lut(ROM_SIZE, a[15:11]) : CADP_NO_PAIR;
      XFER_ACK       <= as_s && (periph_hit || array_hit || rom_hit);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      LOW_WORD_HALF_STROBE    <= 1'b0;
      UPPER_WORD_HALF_STROBE  <= 1'b0;
      LOW_LANE_ENABLE         <= 1'b0;
      HIGH_LANE_ENABLE        <= 1'b0;
      SWAP_LANE_ENABLE        <= 1'b0;
      ONBOARD_IO_ACK          <= 1'b0;
      FAULT_REG_READ_PICK     <= 1'b0;
      XLATE_FLAG_WRITE_STROBE <= 1'b0;
      SUPERVISOR_XLATE_ENABLE <= 1'b0;
      FAULT_IRQ_CLEAR         <= 1'b0;
    end else begin
      LOW_WORD_HALF_STROBE    <= lane.lanes[0];
      UPPER_WORD_HALF_STROBE  <= lane.lanes[1];
      LOW_LANE_ENABLE         <= lane.lanes[2];
      HIGH_LANE_ENABLE        <= lane.lanes[3];
      SWAP_LANE_ENABLE        <= lane.sel && !bhen_s && a[0];
      ONBOARD_IO_ACK          <= io_cmd;
      FAULT_REG_READ_PICK     <= fault_rd;
      XLATE_FLAG_WRITE_STROBE <= flag_wr;
      SUPERVISOR_XLATE_ENABLE <= flag_nxt;
      // One pulse per read; the latched fault contents are kept elsewhere.
      FAULT_IRQ_CLEAR         <= fault_rd && !fault_rd_d_r;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      VALID_ADDRESS_STROBE  <= 1'b0;
      OUTSIDE_USER_FAULT    <= 1'b0;
      WRITE_PROTECT_FAULT   <= 1'b0;
      SEGMENT_INVALID_FAULT <= 1'b0;
      SEGMENT_ABSENT_FAULT  <= 1'b0;
    end else begin
      VALID_ADDRESS_STROBE  <= (mapped && !entry_s[CADP_BIT_NRS] && !entry_s[CADP_BIT_NVS]
                                && (rw_s || !entry_s[CADP_BIT_SWP]))
                            || (as_s && fc_s[2] && (!flag_r || !user_space));
      OUTSIDE_USER_FAULT    <= user_state && !user_space;
      WRITE_PROTECT_FAULT   <= mapped && entry_s[CADP_BIT_SWP] && !rw_s;
      SEGMENT_INVALID_FAULT <= mapped && entry_s[CADP_BIT_NVS];
      SEGMENT_ABSENT_FAULT  <= mapped && entry_s[CADP_BIT_NRS];
    end
  end

endmodule : cadp_decode

// ==== rtl/cadp_pkg.sv ====
package cadp_pkg;
  localparam logic [23:0] CADP_PERIPH_BASE = 24'hE00B00;
  localparam logic [23:0] CADP_ARRAY_LO    = 24'hE00C00;
  localparam logic [23:0] CADP_ARRAY_HI    = 24'hE00FFF;
  localparam logic [23:0] CADP_FLAG_ADDR   = 24'hEFFC01;
  localparam logic [23:0] CADP_FAULT_ADDR  = 24'hEFFD01;
  localparam logic [23:0] CADP_MAP_LO      = 24'hEFF800;
  localparam logic [23:0] CADP_MAP_HI      = 24'hEFFBFF;
  localparam logic [23:0] CADP_ROM_END_2K  = 24'h003FFF;
  localparam logic [23:0] CADP_ROM_END_4K  = 24'h007FFF;
  localparam logic [23:0] CADP_ROM_END_8K  = 24'h00FFFF;
  localparam logic [23:0] CADP_USER_TOP    = 24'h1FFFFF;
  localparam logic [7:0]  CADP_FLAG_ON     = 8'h80;
  localparam logic [3:0]  CADP_NO_PAIR     = 4'hF;
  localparam logic [7:0]  CADP_FAULT_IDLE  = 8'h80;
  localparam int          CADP_LUT_DEPTH   = 32;
  localparam int          CADP_BIT_NRS     = 14;
  localparam int          CADP_BIT_NVS     = 13;
  localparam int          CADP_BIT_SWP     = 12;
  typedef enum logic [1:0] {
    CADP_ROM_2K = 2'h0,
    CADP_ROM_4K = 2'h1,
    CADP_ROM_8K = 2'h2
  } cadp_rom_size_t;
endpackage : cadp_pkg

// ==== rtl/cadp_lane_if.sv ====
interface cadp_lane_if;
  logic       sel;
  logic       a0;
  logic       bhen;
  logic [3:0] lanes;
  modport ctl (output sel, output a0, output bhen, input lanes);
  modport gen (input sel, input a0, input bhen, output lanes);
endinterface : cadp_lane_if

// ==== rtl/cadp_lane_gen.sv ====
module cadp_lane_gen
  import cadp_pkg::*;
(
  cadp_lane_if.gen lane // Byte lane request and result.
);
  // Lanes: 0 low half, 1 upper half, 2 low lane, 3 high lane.
  always_comb begin
    lane.lanes[0] = !lane.a0 || lane.bhen;
    lane.lanes[1] = lane.a0 || lane.bhen;
    lane.lanes[2] = lane.sel && (lane.bhen || !lane.a0);
    lane.lanes[3] = lane.sel && lane.bhen;
  end
endmodule : cadp_lane_gen

// ==== bench/cadp_decode_monitor.sv ====
module cadp_decode_monitor
  import cadp_pkg::*;
#(
  parameter cadp_rom_size_t ROM_SIZE = CADP_ROM_2K
) (
  input wire logic        REF_CLK,                 // Clock.
  input wire logic        RESET_N,                 // Reset.
  input wire logic [23:0] ADDR,                    // Address.
  input wire logic        AS,                      // Strobe.
  input wire logic        RW,                      // Read.
  input wire logic        BHEN,                    // Byte high.
  input wire logic [2:0]  FC,                      // Function code.
  input wire logic        MRDC,                    // Read command.
  input wire logic        MWTC,                    // Write command.
  input wire logic        BUS_HELD_LOCAL,          // Busy.
  input wire logic [7:0]  DATA_IN,                 // Data.
  input wire logic [15:0] MAP_ENTRY,               // Entry.
  input wire logic [15:0] PERIPH_SEL,              // Watched.
  input wire logic        ROM_SEL,                 // Watched.
  input wire logic        XFER_ACK,                // Watched.
  input wire logic        LOW_WORD_HALF_STROBE,    // Watched.
  input wire logic        UPPER_WORD_HALF_STROBE,  // Watched.
  input wire logic        ONBOARD_IO_ACK,          // Watched.
  input wire logic        FAULT_REG_READ_PICK,     // Watched.
  input wire logic        XLATE_FLAG_WRITE_STROBE, // Watched.
  input wire logic        SUPERVISOR_XLATE_ENABLE, // Watched.
  input wire logic        OUTSIDE_USER_FAULT,      // Watched.
  input wire logic        SEGMENT_INVALID_FAULT,   // Watched.
  input wire logic        FAULT_IRQ_CLEAR          // Watched.
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] ROM_END = ROM_SIZE == CADP_ROM_8K ? CADP_ROM_END_8K :
                                    ROM_SIZE == CADP_ROM_4K ? CADP_ROM_END_4K : CADP_ROM_END_2K;
  logic [1:0] age_r;
  logic       warm;
  // The two-stage input pipe and the output register hold reset values until three edges after release.
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) age_r <= 2'h0;
    else if (age_r != 2'h3) age_r <= age_r + 2'h1;
  end
  assign warm = age_r == 2'h3;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  sequence flag_on_wr;
    ADDR[23:11] == 13'h1DFF && MWTC && BUS_HELD_LOCAL && {ADDR[10:8], ADDR[0]} == 4'h8 &&
      DATA_IN == CADP_FLAG_ON && FC != 3'h7;
  endsequence
  sequence pick_rise;
    $rose(FAULT_REG_READ_PICK);
  endsequence
  chk_periph_onehot: assert property (warm |-> PERIPH_SEL == ($past(ADDR[23:8], 3) == 16'hE00B ?
    16'h1 << $past(ADDR[7:4], 3) : 16'h0)) else $error("peripheral select wrong");
  chk_rom_span: assert property (warm |-> ROM_SEL == ($past(ADDR, 3) <= ROM_END))
    else $error("rom select wrong");
  chk_ack_regions: assert property (warm |-> XFER_ACK == ($past(AS, 3) &&
    ($past(ADDR[23:8], 3) == 16'hE00B || $past(ADDR[23:10], 3) == 14'h3803 ||
    $past(ADDR, 3) <= ROM_END))) else $error("transfer ack wrong");
  chk_half_strobes: assert property (warm |-> LOW_WORD_HALF_STROBE ==
    (!$past(ADDR[0], 3) || $past(BHEN, 3)) && UPPER_WORD_HALF_STROBE ==
    ($past(ADDR[0], 3) || $past(BHEN, 3))) else $error("half strobe wrong");
  chk_io_ack: assert property (warm |-> ONBOARD_IO_ACK == ($past(ADDR[23:11], 3) == 13'h1DFF
    && $past(BUS_HELD_LOCAL, 3) && ($past(MRDC, 3) || $past(MWTC, 3))))
    else $error("io ack wrong");
  chk_fault_pick: assert property (warm |-> FAULT_REG_READ_PICK == ($past(MRDC, 3) &&
    $past(ADDR[23:11], 3) == 13'h1DFF && $past({ADDR[10:8], ADDR[0]}, 3) == 4'hA))
    else $error("fault pick wrong");
  chk_flag_strobe: assert property (warm |-> XLATE_FLAG_WRITE_STROBE == ($past(MWTC, 3) &&
    $past(BUS_HELD_LOCAL, 3) && $past(ADDR[23:11], 3) == 13'h1DFF &&
    $past({ADDR[10:8], ADDR[0]}, 3) == 4'h8)) else $error("flag strobe wrong");
  chk_flag_set: assert property (flag_on_wr |-> ##[3:4] SUPERVISOR_XLATE_ENABLE)
    else $error("flag not set");
  chk_outside_user: assert property (warm |-> OUTSIDE_USER_FAULT == (!$past(FC[2], 3) &&
    $past(ADDR, 3) > CADP_USER_TOP)) else $error("outside user fault wrong");
  chk_user_invalid: assert property (warm && !$past(FC[2], 3) |-> SEGMENT_INVALID_FAULT ==
    ($past(AS, 3) && $past(ADDR, 3) <= CADP_USER_TOP && $past(MAP_ENTRY[CADP_BIT_NVS], 3)))
    else $error("invalid segment fault wrong");
  chk_irq_clear: assert property (pick_rise |-> ##[0:1] FAULT_IRQ_CLEAR ##1 !FAULT_IRQ_CLEAR)
    else $error("irq clear pulse wrong");
endmodule : cadp_decode_monitor

bind cadp_decode cadp_decode_monitor #(.ROM_SIZE(ROM_SIZE)) i_mon (.*);

// ==== bench/cadp_cpu_model.sv ====
module cadp_cpu_model
  import cadp_pkg::*;
(
  input  wire logic  REF_CLK,        // Bus clock.
  output logic [23:0] ADDR,          // Address.
  output logic        AS,            // Strobe.
  output logic        RW,            // Read.
  output logic        BHEN,          // Byte high.
  output logic [2:0]  FC,            // Function code.
  output logic        MRDC,          // Read command.
  output logic        MWTC,          // Write command.
  output logic        BUS_HELD_LOCAL, // Busy.
  output logic [7:0]  DATA_IN,       // Data.
  output logic [15:0] MAP_ENTRY      // Entry.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {ADDR, AS, RW, BHEN, FC, MRDC, MWTC, BUS_HELD_LOCAL, DATA_IN, MAP_ENTRY} = '0;
  // One bus cycle, held long enough for the three-edge decode lag to settle.
  task automatic put(input logic [23:0] a, input logic [2:0] f, input logic [5:0] c,
                     input logic [7:0] d, input logic [15:0] e);
    @(posedge REF_CLK);
    #1;
    {ADDR, FC, DATA_IN, MAP_ENTRY} = {a, f, d, e};
    {AS, RW, BHEN, MRDC, MWTC, BUS_HELD_LOCAL} = c;
    repeat (3) @(posedge REF_CLK);
    #1;
  endtask : put
  task automatic flag(input logic on);
    put(24'hEFFC00, 3'h5, 6'h23, on ? CADP_FLAG_ON : 8'h00, 16'h0000);
  endtask : flag
endmodule : cadp_cpu_model

// ==== bench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic [23:0] ADDR;
  logic [2:0]  FC;
  logic [7:0]  DATA_IN;
  logic [15:0] MAP_ENTRY, PERIPH_SEL;
  logic [3:0]  ROM_PAIR_SEL_N;
  logic AS, RW, BHEN, MRDC, MWTC, BUS_HELD_LOCAL, ARRAY_SEL, ROM_SEL, XFER_ACK;
  logic LOW_WORD_HALF_STROBE, UPPER_WORD_HALF_STROBE, LOW_LANE_ENABLE, HIGH_LANE_ENABLE;
  logic SWAP_LANE_ENABLE, ONBOARD_IO_ACK, FAULT_REG_READ_PICK, XLATE_FLAG_WRITE_STROBE;
  logic SUPERVISOR_XLATE_ENABLE, VALID_ADDRESS_STROBE, OUTSIDE_USER_FAULT, FAULT_IRQ_CLEAR;
  logic WRITE_PROTECT_FAULT, SEGMENT_INVALID_FAULT, SEGMENT_ABSENT_FAULT;
  logic [3:0]  pair4_n;
  logic        rom4;
  // Expected pair selects of the 4Kx8 lookup for entries 0 to 8.
  logic [3:0]  lut4 [9] = '{4'hE, 4'hE, 4'hD, 4'hD, 4'hB, 4'h7, 4'h7, 4'hF, 4'hF};
  int   n_mismatch = 0;
  int   compares = 0;
  always #25 REF_CLK = ~REF_CLK;
  cadp_decode    i_dut (.*);
  cadp_cpu_model i_cpu (.*);
  // A second decoder fitted for 4Kx8 parts shares the bus, so its lookup is exercised too.
  cadp_decode #(.ROM_SIZE(cadp_pkg::CADP_ROM_4K)) i_dut4 (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .AS(AS), .RW(RW), .BHEN(BHEN),
    .FC(FC), .MRDC(MRDC), .MWTC(MWTC), .BUS_HELD_LOCAL(BUS_HELD_LOCAL), .DATA_IN(DATA_IN),
    .MAP_ENTRY(MAP_ENTRY), .PERIPH_SEL(), .ARRAY_SEL(), .ROM_SEL(rom4),
    .ROM_PAIR_SEL_N(pair4_n), .XFER_ACK(), .LOW_WORD_HALF_STROBE(),
    .UPPER_WORD_HALF_STROBE(), .LOW_LANE_ENABLE(), .HIGH_LANE_ENABLE(),
    .SWAP_LANE_ENABLE(), .ONBOARD_IO_ACK(), .FAULT_REG_READ_PICK(),
    .XLATE_FLAG_WRITE_STROBE(), .SUPERVISOR_XLATE_ENABLE(), .VALID_ADDRESS_STROBE(),
    .OUTSIDE_USER_FAULT(), .WRITE_PROTECT_FAULT(), .SEGMENT_INVALID_FAULT(),
    .SEGMENT_ABSENT_FAULT(), .FAULT_IRQ_CLEAR()
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hit(input logic [23:0] a, input logic [2:0] e);
    i_cpu.put(a, 3'h5, 6'h30, 8'h00, 16'h0000);
    chk({ARRAY_SEL, ROM_SEL, XFER_ACK}, e);
  endtask : hit
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge REF_CLK);
    #1;
    chk({ROM_PAIR_SEL_N, XFER_ACK}, 5'h1E);
    RESET_N = 1'b1;
    hit(24'h000000, 3'h3);
    chk(ROM_PAIR_SEL_N, 4'hE);
    hit(24'h003FFF, 3'h3);
    hit(24'h004000, 3'h0);
    hit(24'h020000, 3'h0);
    hit(24'hEFF7FF, 3'h0);
    hit(24'hF00000, 3'h0);
    hit(24'hE00C00, 3'h5);
    hit(24'hE00FFF, 3'h5);
    hit(24'hEFF800, 3'h4);
    hit(24'hEFFBFF, 3'h4);
    for (int d = 0; d < 16; d++) begin
      hit(24'hE00B00 | 24'(d << 4), 3'h1);
      chk(PERIPH_SEL, 16'h1 << d);
    end
    $display("test decode done");
    for (int e = 0; e < 9; e++) begin
      i_cpu.put(24'(e << 11), 3'h5, 6'h30, 8'h00, 16'h0000);
      chk({rom4, pair4_n}, {1'b1, lut4[e]});
    end
    i_cpu.put(24'h007FFF, 3'h5, 6'h30, 8'h00, 16'h0000);
    chk({rom4, pair4_n}, 5'h1F);
    i_cpu.put(24'h008000, 3'h5, 6'h30, 8'h00, 16'h0000);
    chk({rom4, pair4_n}, 5'h0F);
    $display("test rom lookup done");
    for (int k = 0; k < 4; k++) begin
      i_cpu.put({23'h0, k[0]}, 3'h5, {2'h3, k[1], 3'h0}, 8'h00, 16'h0000);
      chk({LOW_WORD_HALF_STROBE, UPPER_WORD_HALF_STROBE}, {!k[0] | k[1], k[0] | k[1]});
      chk({LOW_LANE_ENABLE, HIGH_LANE_ENABLE, SWAP_LANE_ENABLE}, {!k[0] | k[1], k[1], k[0] & !k[1]});
    end
    $display("test lanes done");
    i_cpu.put(24'hEFFD00, 3'h5, 6'h35, 8'h00, 16'h0000);
    chk({ONBOARD_IO_ACK, FAULT_REG_READ_PICK, XLATE_FLAG_WRITE_STROBE}, 3'h6);
    chk(FAULT_IRQ_CLEAR, 1'b1);
    i_cpu.put(24'hEFFD00, 3'h5, 6'h34, 8'h00, 16'h0000);
    chk({ONBOARD_IO_ACK, FAULT_REG_READ_PICK}, 2'h1);
    chk(FAULT_IRQ_CLEAR, 1'b0);
    i_cpu.flag(1'b1);
    chk(XLATE_FLAG_WRITE_STROBE, 1'b1);
    i_cpu.put(24'h001000, 3'h1, 6'h30, 8'h00, 16'h2000);
    chk({SUPERVISOR_XLATE_ENABLE, SEGMENT_INVALID_FAULT, VALID_ADDRESS_STROBE}, 3'h6);
    i_cpu.put(24'h001000, 3'h5, 6'h30, 8'h00, 16'h0000);
    chk(VALID_ADDRESS_STROBE, 1'b1);
    i_cpu.put(24'h001000, 3'h5, 6'h20, 8'h00, 16'h1000);
    chk({WRITE_PROTECT_FAULT, VALID_ADDRESS_STROBE}, 2'h2);
    i_cpu.put(24'h001000, 3'h1, 6'h30, 8'h00, 16'h4000);
    chk({SEGMENT_ABSENT_FAULT, VALID_ADDRESS_STROBE}, 2'h2);
    i_cpu.put(24'h200000, 3'h1, 6'h30, 8'h00, 16'h0000);
    chk({OUTSIDE_USER_FAULT, VALID_ADDRESS_STROBE}, 2'h2);
    i_cpu.put(24'h000000, 3'h7, 6'h30, 8'h00, 16'h0000);
    i_cpu.put(24'h001000, 3'h5, 6'h30, 8'h00, 16'h2000);
    chk({SUPERVISOR_XLATE_ENABLE, SEGMENT_INVALID_FAULT, VALID_ADDRESS_STROBE}, 3'h1);
    i_cpu.flag(1'b1);
    i_cpu.flag(1'b0);
    i_cpu.put(24'h001000, 3'h5, 6'h30, 8'h00, 16'h0000);
    chk(SUPERVISOR_XLATE_ENABLE, 1'b0);
    $display("test translate done");
    give_verdict();
  end
endmodule : tb
